/* File: core/ecf_regs.svh */
// register offsets, field positions, reset values for the filter config bank
// assumes an APB slave with 32-bit data, one register per aligned word
`ifndef ECF_REGS_SVH
`define ECF_REGS_SVH
`define ECF_IDX_STATUS     6'h02
`define ECF_IDX_DCOFF      6'h03
`define ECF_IDX_HPF        6'h04
`define ECF_IDX_MU         6'h05
`define ECF_IDX_SIG        6'h07
`define ECF_IDX_SAT1       6'h08
`define ECF_IDX_SAT2       6'h09
`define ECF_IDX_BOOT       6'h3F
`define ECF_IDX_IRQ_STAT   6'h10
`define ECF_IDX_IRQ_MASK   6'h11
`define ECF_RST_DCOFF      8'h60
`define ECF_RST_HPF        8'hA1
`define ECF_RST_MU         8'h08
`define ECF_RST_SIG        8'hFF
`define ECF_RST_SAT1       8'h80
`define ECF_RST_SAT2       8'h04
`define ECF_RST_BOOT       8'h08
`define ECF_SAT_UNITY      16'h8000
`define ECF_BIT_FALSE_HOWL_FLAG      5
`define ECF_BIT_NB         1
`define ECF_BIT_NBR        0
`define ECF_BIT_BOOTEN     0
`define ECF_HPF_FR_LSB     5
`define ECF_MU_MAX         6'h3F
`endif

/* File: core/ecf_pkg.sv */
// types shared by the filter config bank
// assumes ecf_regs.svh supplies the numeric constants
package ecf_pkg;
  typedef struct packed {
    logic [2:0] rx_code;
    logic [4:0] tx_code;
  } ecf_hpf_t;
  typedef struct packed {
    logic       false_howl;
    logic       nb_receive;
    logic       nb_send;
  } ecf_det_t;
  typedef enum logic [2:0] {
    ECF_IDLE   = 3'b001,
    ECF_SETUP  = 3'b010,
    ECF_ACCESS = 3'b100
  } ecf_apb_st_t;
endpackage : ecf_pkg

/* File: core/ecf_filter_cfg.sv */
// register bank for echo canceller filter configuration and status
// assumes APB master, datapath supplies detector flags and bootload bytes
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`include "ecf_regs.svh"
module ecf_filter_cfg
  import ecf_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLK,
  input  wire logic              NRST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire ecf_det_t          DET_IN,
  input  wire logic [4:0]        MUTE_OFFSET_IN,
  input  wire logic              BOOT_BYTE_VALID,
  input  wire logic [7:0]        BOOT_BYTE,
  output ecf_hpf_t               HPF_CODES,
  output logic      [5:0]        ADAPT_STEP,
  output logic      [15:0]       SLOW_THRESHOLD,
  output logic                   BOOT_EN,
  output logic                   IRQ
);

  if (ADDR_W < 8) begin : g_addr_w_check
    $error("ADDR_W must be at least 8");
  end

  ecf_hpf_t   hpf_reg;
  logic [5:0] mu_reg;
  logic [7:0] sat1_reg;
  logic [7:0] sat2_reg;
  logic [7:0] boot_ctl_reg;
  logic [7:0] sig_reg;
  logic [7:0] dcoff_reg;
  ecf_det_t   det_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_stat_next;
  logic       wr_en;
  logic       rd_en;
  logic       bad_addr;
  logic [5:0] idx;
  logic       boot_en;

  // word index from byte address
  function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
    return a[7:2];
  endfunction : word_idx

  // signature step: rotate left then xor the byte
  function automatic logic [7:0] sig_step(input logic [7:0] s, input logic [7:0] b);
    return {s[6:0], s[7]} ^ b;
  endfunction : sig_step

  assign idx     = word_idx(PADDR);
  assign boot_en = boot_ctl_reg[`ECF_BIT_BOOTEN];
  assign PREADY  = 1'b1;
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && PENABLE && !PWRITE;

  // decode, also flags signature access outside bootload
  always_comb begin
    if (PADDR[1:0] != 2'b00) bad_addr = 1'b1;
    else if (idx == `ECF_IDX_STATUS || idx == `ECF_IDX_DCOFF) bad_addr = 1'b0;
    else if (idx == `ECF_IDX_HPF || idx == `ECF_IDX_MU) bad_addr = 1'b0;
    else if (idx == `ECF_IDX_SIG) bad_addr = !boot_en || PWRITE;
    else if (idx == `ECF_IDX_SAT1 || idx == `ECF_IDX_SAT2) bad_addr = 1'b0;
    else if (idx == `ECF_IDX_BOOT) bad_addr = 1'b0;
    else if (idx == `ECF_IDX_IRQ_STAT || idx == `ECF_IDX_IRQ_MASK) bad_addr = 1'b0;
    else bad_addr = 1'b1;
  end
  assign PSLVERR = PSEL && PENABLE && bad_addr;

  // configuration registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      hpf_reg      <= `ECF_RST_HPF;
      mu_reg       <= 6'(`ECF_RST_MU);
      sat1_reg     <= `ECF_RST_SAT1;
      sat2_reg     <= `ECF_RST_SAT2;
      boot_ctl_reg <= `ECF_RST_BOOT;
      irq_mask_reg <= 3'h0;
    end else if (wr_en && !bad_addr && PSTRB[0]) begin
      if (idx == `ECF_IDX_HPF) hpf_reg <= PWDATA[7:0];
      else if (idx == `ECF_IDX_MU) mu_reg <= PWDATA[5:0];
      else if (idx == `ECF_IDX_SAT1) sat1_reg <= PWDATA[7:0];
      else if (idx == `ECF_IDX_SAT2) sat2_reg <= PWDATA[7:0];
      else if (idx == `ECF_IDX_BOOT) boot_ctl_reg <= PWDATA[7:0];
      else if (idx == `ECF_IDX_IRQ_MASK) irq_mask_reg <= PWDATA[2:0];
    end
  end

  // detector snapshot and dc offset readout
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      det_reg   <= '0;
      dcoff_reg <= `ECF_RST_DCOFF;
    end else begin
      det_reg   <= DET_IN;
      dcoff_reg <= {3'h0, MUTE_OFFSET_IN};
    end
  end

  // bootload signature accumulator
  always_ff @(posedge CLK) begin
    if (!NRST) sig_reg <= `ECF_RST_SIG;
    else if (!boot_en) sig_reg <= `ECF_RST_SIG;
    else if (BOOT_BYTE_VALID) sig_reg <= sig_step(sig_reg, BOOT_BYTE);
  end

  // sticky events, set beats write-one clear
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_en && idx == `ECF_IDX_IRQ_STAT && PSTRB[0] && PADDR[1:0] == 2'b00)
      irq_stat_next = irq_stat_next & ~PWDATA[2:0];
    irq_stat_next = irq_stat_next | {DET_IN.false_howl, DET_IN.nb_receive, DET_IN.nb_send};
  end
  always_ff @(posedge CLK) begin
    if (!NRST) irq_stat_reg <= 3'h0;
    else irq_stat_reg <= irq_stat_next;
  end
  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  // read data
  always_ff @(posedge CLK) begin
    if (!NRST) PRDATA <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= 32'h0000_0000;
      if (PADDR[1:0] != 2'h0) PRDATA[7:0] <= 8'h00;
      else if (idx == `ECF_IDX_STATUS)
        PRDATA[7:0] <= {2'b00, det_reg.false_howl, 3'b000,
                        det_reg.nb_receive | det_reg.nb_send, det_reg.nb_receive};
      else if (idx == `ECF_IDX_DCOFF) PRDATA[7:0] <= dcoff_reg;
      else if (idx == `ECF_IDX_HPF) PRDATA[7:0] <= hpf_reg;
      else if (idx == `ECF_IDX_MU) PRDATA[7:0] <= {2'b00, mu_reg};
      else if (idx == `ECF_IDX_SIG && boot_en) PRDATA[7:0] <= sig_reg;
      else if (idx == `ECF_IDX_SAT1) PRDATA[7:0] <= sat1_reg;
      else if (idx == `ECF_IDX_SAT2) PRDATA[7:0] <= sat2_reg;
      else if (idx == `ECF_IDX_BOOT) PRDATA[7:0] <= boot_ctl_reg;
      else if (idx == `ECF_IDX_IRQ_STAT) PRDATA[2:0] <= irq_stat_reg;
      else if (idx == `ECF_IDX_IRQ_MASK) PRDATA[2:0] <= irq_mask_reg;
    end
  end

  assign HPF_CODES      = hpf_reg;
  assign ADAPT_STEP     = mu_reg;
  assign SLOW_THRESHOLD = {sat2_reg, sat1_reg};
  assign BOOT_EN        = boot_en;

  property p_sig_seed;
    @(posedge CLK) disable iff (!NRST) !boot_en |=> sig_reg == `ECF_RST_SIG;
  endproperty
  a_sig_seed: assert property (p_sig_seed) else $error("signature left seed");

  property p_sig_step;
    @(posedge CLK) disable iff (!NRST)
      boot_en && BOOT_BYTE_VALID |=> sig_reg == sig_step($past(sig_reg), $past(BOOT_BYTE));
  endproperty
  a_sig_step: assert property (p_sig_step) else $error("signature not accumulated");

  property p_sig_hold;
    @(posedge CLK) disable iff (!NRST) boot_en && !BOOT_BYTE_VALID ##1 boot_en |-> $stable(sig_reg);
  endproperty
  a_sig_hold: assert property (p_sig_hold) else $error("signature moved without data");

  property p_sig_gate;
    @(posedge CLK) disable iff (!NRST)
      PSEL && PENABLE && idx == `ECF_IDX_SIG && !boot_en |-> PSLVERR;
  endproperty
  a_sig_gate: assert property (p_sig_gate) else $error("signature reachable outside bootload");

  property p_nb_or;
    @(posedge CLK) disable iff (!NRST)
      rd_en && idx == `ECF_IDX_STATUS && PADDR[1:0] == 2'b00 |->
        PRDATA[`ECF_BIT_NB] == (PRDATA[`ECF_BIT_NBR] | $past(det_reg.nb_send));
  endproperty
  a_nb_or: assert property (p_nb_or) else $error("narrowband summary wrong");

  property p_hpf_write;
    @(posedge CLK) disable iff (!NRST)
      wr_en && idx == `ECF_IDX_HPF && PSTRB[0] && PADDR[1:0] == 2'b00 |=>
        HPF_CODES.tx_code == $past(PWDATA[4:0]) && HPF_CODES.rx_code == $past(PWDATA[7:5]);
  endproperty
  a_hpf_write: assert property (p_hpf_write) else $error("cutoff codes not taken");

  property p_sat_write;
    @(posedge CLK) disable iff (!NRST)
      wr_en && idx == `ECF_IDX_SAT2 && PSTRB[0] && PADDR[1:0] == 2'b00 |=>
        SLOW_THRESHOLD[15:8] == $past(PWDATA[7:0]);
  endproperty
  a_sat_write: assert property (p_sat_write) else $error("threshold high byte not taken");

  property p_irq_sticky;
    @(posedge CLK) disable iff (!NRST) DET_IN.false_howl |=> irq_stat_reg[2] [*2];
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("howl event lost");

  // bus answer checks
  property p_rd_upper_zero;
    @(posedge CLK) disable iff (!NRST)
      rd_en |-> PRDATA[31:8] == 24'h000000;
  endproperty
  a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("read data upper bits set");

  property p_rd_err_zero;
    @(posedge CLK) disable iff (!NRST)
      rd_en && PSLVERR |-> PRDATA == 32'h0000_0000;
  endproperty
  a_rd_err_zero: assert property (p_rd_err_zero) else $error("refused read returned data");

  property p_err_misaligned;
    @(posedge CLK) disable iff (!NRST)
      PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR;
  endproperty
  a_err_misaligned: assert property (p_err_misaligned) else $error("misaligned access accepted");

  property p_err_no_write;
    @(posedge CLK) disable iff (!NRST)
      wr_en && PSLVERR |=>
        $stable(HPF_CODES) && $stable(ADAPT_STEP) && $stable(SLOW_THRESHOLD) && $stable(BOOT_EN);
  endproperty
  a_err_no_write: assert property (p_err_no_write) else $error("refused write changed a register");

  // register update and readout checks
  property p_hpf_hold;
    @(posedge CLK) disable iff (!NRST)
      !(wr_en && idx == `ECF_IDX_HPF) |=> $stable(HPF_CODES);
  endproperty
  a_hpf_hold: assert property (p_hpf_hold) else $error("cutoff codes moved without a write");

  property p_mu_write;
    @(posedge CLK) disable iff (!NRST)
      wr_en && idx == `ECF_IDX_MU && PSTRB[0] && PADDR[1:0] == 2'h0 |=>
        ADAPT_STEP == $past(PWDATA[5:0]);
  endproperty
  a_mu_write: assert property (p_mu_write) else $error("step constant not taken");

  property p_mu_hold;
    @(posedge CLK) disable iff (!NRST)
      !(wr_en && idx == `ECF_IDX_MU) |=> $stable(ADAPT_STEP);
  endproperty
  a_mu_hold: assert property (p_mu_hold) else $error("step constant moved without a write");

  property p_sat_low_write;
    @(posedge CLK) disable iff (!NRST)
      wr_en && idx == `ECF_IDX_SAT1 && PSTRB[0] && PADDR[1:0] == 2'h0 |=>
        SLOW_THRESHOLD[7:0] == $past(PWDATA[7:0]);
  endproperty
  a_sat_low_write: assert property (p_sat_low_write) else $error("threshold low byte not taken");

  property p_sat_hold;
    @(posedge CLK) disable iff (!NRST)
      !(wr_en && (idx == `ECF_IDX_SAT1 || idx == `ECF_IDX_SAT2)) |=>
        $stable(SLOW_THRESHOLD);
  endproperty
  a_sat_hold: assert property (p_sat_hold) else $error("threshold moved without a write");

  property p_boot_write;
    @(posedge CLK) disable iff (!NRST)
      wr_en && idx == `ECF_IDX_BOOT && PSTRB[0] && PADDR[1:0] == 2'h0 |=>
        BOOT_EN == $past(PWDATA[`ECF_BIT_BOOTEN]);
  endproperty
  a_boot_write: assert property (p_boot_write) else $error("boot enable not taken");

  property p_dcoff;
    @(posedge CLK) disable iff (!NRST)
      rd_en && idx == `ECF_IDX_DCOFF && PADDR[1:0] == 2'h0 |->
        PRDATA[7:0] == {3'h0, $past(MUTE_OFFSET_IN, 2)};
  endproperty
  a_dcoff: assert property (p_dcoff) else $error("dc offset readout wrong");

  property p_status_fields;
    @(posedge CLK) disable iff (!NRST)
      rd_en && idx == `ECF_IDX_STATUS && PADDR[1:0] == 2'h0 |->
        PRDATA[`ECF_BIT_FALSE_HOWL_FLAG] == $past(DET_IN.false_howl, 2) && PRDATA[`ECF_BIT_NBR] == $past(DET_IN.nb_receive, 2);
  endproperty
  a_status_fields: assert property (p_status_fields) else $error("status flags wrong");

  property p_sig_read;
    @(posedge CLK) disable iff (!NRST)
      rd_en && idx == `ECF_IDX_SIG && PADDR[1:0] == 2'h0 && boot_en |->
        !PSLVERR && PRDATA[7:0] == $past(sig_reg);
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("signature not readable in bootload");

  // event checks
  property p_irq_set_wins;
    @(posedge CLK) disable iff (!NRST)
      DET_IN.nb_send |=> irq_stat_reg[0];
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("send narrowband event lost");

  property p_irq_clear;
    @(posedge CLK) disable iff (!NRST)
      wr_en && idx == `ECF_IDX_IRQ_STAT && PSTRB[0] && PADDR[1:0] == 2'h0 && PWDATA[2] && !DET_IN.false_howl |=>
        !irq_stat_reg[2];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("howl event not cleared");

  property p_irq_hold;
    @(posedge CLK) disable iff (!NRST)
      !DET_IN.nb_receive && !(wr_en && idx == `ECF_IDX_IRQ_STAT) |=>
        $stable(irq_stat_reg[1]);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("receive narrowband event moved");

  c_boot: cover property (@(posedge CLK) disable iff (!NRST) boot_en && BOOT_BYTE_VALID ##1 rd_en && idx == `ECF_IDX_SIG);
  c_irq: cover property (@(posedge CLK) disable iff (!NRST) $rose(IRQ));
  c_err: cover property (@(posedge CLK) disable iff (!NRST) PSLVERR);
  c_sig_refused: cover property (@(posedge CLK) disable iff (!NRST) wr_en && idx == `ECF_IDX_SIG && PSLVERR);
  c_misaligned: cover property (@(posedge CLK) disable iff (!NRST) rd_en && PADDR[1:0] != 2'h0);

endmodule : ecf_filter_cfg

/* File: verification/ecf_testbench.sv */
// self-checking bench for the filter config register bank
// assumes ecf_pkg compiled first and ecf_regs.svh on the include path
`timescale 1ns/100ps
`include "ecf_regs.svh"
module testbench
  import ecf_pkg::*;
;
  logic        CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, BOOT_BYTE_VALID, BOOT_EN, IRQ;
  logic [7:0]  PADDR, BOOT_BYTE;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0]  PSTRB;
  logic [4:0]  MUTE_OFFSET_IN;
  logic [5:0]  ADAPT_STEP;
  logic [15:0] SLOW_THRESHOLD;
  logic        err;
  logic [1:0]  addr_lo;
  ecf_det_t    DET_IN;
  ecf_hpf_t    HPF_CODES;
  int          fail_count, tests_run, cycles;
  ecf_filter_cfg #(.ADDR_W(8)) dut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DET_IN(DET_IN), .MUTE_OFFSET_IN(MUTE_OFFSET_IN), .BOOT_BYTE_VALID(BOOT_BYTE_VALID), .BOOT_BYTE(BOOT_BYTE),
    .HPF_CODES(HPF_CODES), .ADAPT_STEP(ADAPT_STEP), .SLOW_THRESHOLD(SLOW_THRESHOLD), .BOOT_EN(BOOT_EN), .IRQ(IRQ));
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // one apb transfer, waits for pready, the run timeout bounds the wait
  task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1; PWRITE <= w; PADDR <= {idx, addr_lo}; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask : apb
  task rdchk(input logic [5:0] idx, input logic [31:0] exp, input logic experr, input string msg);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp, msg);
    chk({31'h0, err}, {31'h0, experr}, "slverr");
  endtask : rdchk
  task boot_byte(input logic [7:0] b);
    @(posedge CLK);
    BOOT_BYTE_VALID <= 1'b1; BOOT_BYTE <= b;
    @(posedge CLK);
    BOOT_BYTE_VALID <= 1'b0;
  endtask : boot_byte
  task test_reset_values;
    rdchk(`ECF_IDX_HPF, 32'h000000A1, 1'b0, "hpf reset");
    rdchk(`ECF_IDX_MU, 32'h00000008, 1'b0, "mu reset");
    rdchk(`ECF_IDX_SIG, 32'h0, 1'b1, "sig closed");
    rdchk(6'h01, 32'h0, 1'b1, "unmapped");
    rdchk(`ECF_IDX_DCOFF, 32'h0000000A, 1'b0, "dc offset");
    addr_lo = 2'h1;
    rdchk(`ECF_IDX_HPF, 32'h0, 1'b1, "misaligned");
    addr_lo = 2'h0;
    chk({16'h0, SLOW_THRESHOLD}, 32'h00000480, "sat reset");
    chk({26'h0, ADAPT_STEP}, 32'h00000008, "step out reset");
    chk({30'h0, BOOT_EN, IRQ}, 32'h0, "boot and irq reset");
  endtask : test_reset_values
  task test_step;
    apb(1'b1, `ECF_IDX_MU, {26'h0, `ECF_MU_MAX});
    @(posedge CLK);
    chk({26'h0, ADAPT_STEP}, {26'h0, `ECF_MU_MAX}, "step largest");
  endtask : test_step
  task test_hpf;
    apb(1'b1, `ECF_IDX_HPF, 32'h0000001F);
    @(posedge CLK);
    chk({24'h0, HPF_CODES}, 32'h0000001F, "send code lowest");
    apb(1'b1, `ECF_IDX_HPF, 32'h000000E0);
    @(posedge CLK);
    chk({29'h0, HPF_CODES.rx_code}, 32'h7, "receive code lowest");
    chk({27'h0, HPF_CODES.tx_code}, 32'h0, "send code highest");
  endtask : test_hpf
  task test_threshold;
    apb(1'b1, `ECF_IDX_SAT1, 32'h00000000);
    apb(1'b1, `ECF_IDX_SAT2, 32'h00000080);
    @(posedge CLK);
    chk({16'h0, SLOW_THRESHOLD}, {16'h0, `ECF_SAT_UNITY}, "unity threshold");
    rdchk(`ECF_IDX_SAT2, 32'h00000080, 1'b0, "sat high byte");
  endtask : test_threshold
  task test_narrowband;
    DET_IN <= 3'b001;
    repeat (3) @(posedge CLK);
    rdchk(`ECF_IDX_STATUS, 32'h00000002, 1'b0, "nb send only");
    chk({31'h0, IRQ}, 32'h0, "masked irq");
    DET_IN <= 3'b010;
    repeat (3) @(posedge CLK);
    rdchk(`ECF_IDX_STATUS, 32'h00000003, 1'b0, "nb receive");
    DET_IN <= 3'b000;
  endtask : test_narrowband
  task test_irq;
    apb(1'b1, `ECF_IDX_IRQ_STAT, 32'h00000007);
    apb(1'b1, `ECF_IDX_IRQ_MASK, 32'h00000004);
    DET_IN <= 3'b100;
    repeat (3) @(posedge CLK);
    rdchk(`ECF_IDX_STATUS, 32'h00000020, 1'b0, "false howl flag");
    DET_IN <= 3'b000;
    chk({31'h0, IRQ}, 32'h1, "howl irq");
    rdchk(`ECF_IDX_IRQ_STAT, 32'h00000004, 1'b0, "howl sticky");
    apb(1'b1, `ECF_IDX_IRQ_STAT, 32'h00000004);
    @(posedge CLK);
    chk({31'h0, IRQ}, 32'h0, "irq cleared");
  endtask : test_irq
  task test_signature;
    boot_byte(8'h55);
    apb(1'b1, `ECF_IDX_BOOT, 32'h00000009);
    rdchk(`ECF_IDX_SIG, 32'h000000FF, 1'b0, "sig seed");
    chk({31'h0, BOOT_EN}, 32'h1, "boot enable out");
    boot_byte(8'h3C);
    boot_byte(8'hA5);
    rdchk(`ECF_IDX_SIG, 32'h00000022, 1'b0, "sig two bytes");
    apb(1'b1, `ECF_IDX_SIG, 32'h00000000);
    chk({31'h0, err}, 32'h1, "sig write refused");
    apb(1'b1, `ECF_IDX_BOOT, 32'h00000008);
    boot_byte(8'h11);
    apb(1'b1, `ECF_IDX_BOOT, 32'h00000009);
    rdchk(`ECF_IDX_SIG, 32'h000000FF, 1'b0, "sig held at seed");
  endtask : test_signature
  initial begin
    fail_count = 0; tests_run = 0; cycles = 0; addr_lo = 2'h0;
    NRST = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 8'h00; PWDATA = 32'h0;
    PSTRB = 4'hF; DET_IN = 3'b000; MUTE_OFFSET_IN = 5'h0A; BOOT_BYTE_VALID = 1'b0; BOOT_BYTE = 8'h00;
    repeat (6) @(posedge CLK);
    NRST <= 1'b1;
    test_reset_values();
    test_hpf();
    test_step();
    test_threshold();
    test_narrowband();
    test_irq();
    test_signature();
    print_verdict();
  end
endmodule : testbench
